//--- logic/alarm_event_pkg.sv
// constants, types and register map of the per-line alarm event block
package alarm_event_pkg;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_ALARM_STATUS = 8'hB9;
	localparam logic [7:0] IDX_ALARM_IRQ_EN = 8'hBA;
	localparam logic [7:0] IDX_ALARM_FLAGS  = 8'hBB;
	localparam logic [7:0] IDX_CRITERIA     = 8'hBC;
	localparam logic [7:0] IDX_UPDATE_CTRL  = 8'hC2;
	localparam logic [7:0] IDX_OVF_EN_A     = 8'hC3;
	localparam logic [7:0] IDX_OVF_EN_B     = 8'hC4;
	localparam logic [7:0] IDX_OVF_FLAGS_A  = 8'hC5;
	localparam logic [7:0] IDX_OVF_FLAGS_B  = 8'hC6;

	// alarm bit positions
	localparam int BIT_RED      = 0;
	localparam int BIT_REMOTE   = 1;
	localparam int BIT_ALL_ONES = 2;
	localparam int BIT_REM_MF   = 3;
	localparam int BIT_TS16_AO  = 4;
	localparam int BIT_TS16_LOS = 5;
	// criteria, update control and line code overflow bit positions
	localparam int BIT_ALL_ONES_SEL = 1;
	localparam int BIT_REMOTE_SEL   = 0;
	localparam int BIT_MANUAL       = 1;
	localparam int BIT_AUTO         = 0;
	localparam int BIT_LCV          = 0;

	localparam int ALARM_BITS = 6;
	localparam int OVF_BITS   = 8;

	localparam logic [5:0] ALARM_RESET = 6'h00;
	localparam logic [7:0] OVF_RESET   = 8'h00;

	// timing
	localparam int unsigned CLK_MHZ            = 125;
	localparam int unsigned RED_PERSIST_MS     = 100;
	localparam int unsigned RED_PERSIST_CYCLES = RED_PERSIST_MS * CLK_MHZ * 1000;
	localparam int unsigned SNAP_PERIOD_S      = 1;
	localparam int unsigned SNAP_PERIOD_CYCLES = SNAP_PERIOD_S * CLK_MHZ * 1000000;
	localparam int          RED_CNT_W          = 24;
	localparam int          SEC_CNT_W          = 27;

	// all-ones and remote alarm criteria
	localparam int unsigned AIS_WINDOW_BITS = 512;
	localparam logic [8:0]  AIS_WIN_LAST    = 9'(AIS_WINDOW_BITS - 1);
	localparam logic [1:0]  AIS_FEW_ZEROS   = 2'h3;
	localparam logic [2:0]  REMOTE_ONES     = 3'h4;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic       in_frame_align;
		logic       ts_sixteen_loss_state;
		logic       ts_sixteen_ais_state;
		logic       remote_mf_alarm_state;
		logic       line_bit_valid;
		logic       line_bit;
		logic       a_bit_valid;
		logic       a_bit;
		logic [7:0] ovf_event;
		logic       lcv_ovf_event;
	} framer_in_type;

	typedef struct packed {
		logic [5:0]           alarm_irq_en;
		logic [5:0]           alarm_change_flags;
		logic [5:0]           alarm_prev;
		logic                 all_ones_criterion_sel;
		logic                 remote_alarm_criterion_sel;
		logic                 manual_counter_snapshot;
		logic                 auto_counter_snapshot_en;
		logic [7:0]           ovf_irq_en;
		logic                 line_code_viol_ovf_irq_en;
		logic [7:0]           ovf_flags;
		logic                 line_code_viol_ovf_flag;
		logic                 red_alarm_state;
		logic                 all_ones_alarm_state;
		logic                 remote_alarm_state;
		logic [RED_CNT_W-1:0] red_cnt;
		logic [SEC_CNT_W-1:0] sec_cnt;
		logic [8:0]           win_cnt;
		logic [1:0]           zero_cnt;
		logic                 prev_few;
		logic                 prev_many;
		logic [2:0]           a_ones;
		logic                 snapshot;
		logic [31:0]          prdata;
	} state_type;

endpackage : alarm_event_pkg

//--- logic/e1_alarm_event_ctrl.sv
// per-line alarm change, overflow and counter snapshot logic with apb registers
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module e1_alarm_event_ctrl #(
	parameter int unsigned RED_CYCLES  = alarm_event_pkg::RED_PERSIST_CYCLES,
	parameter int unsigned SNAP_CYCLES = alarm_event_pkg::SNAP_PERIOD_CYCLES
) (
	input  wire logic                          CLK_I,
	input  wire logic                          SYS_RST_I,
	input  wire alarm_event_pkg::apb_req_type   APB_I,
	output      alarm_event_pkg::apb_rsp_type   APB_O,
	input  wire alarm_event_pkg::framer_in_type FRAMER_I,
	output logic                                INT_N_O,
	output logic                                SNAPSHOT_O
);
	import alarm_event_pkg::*;

	state_type   st_reg;
	state_type   st_next;
	logic        access;
	logic        setup;
	logic        hit;
	logic        wr;
	logic [7:0]  idx;
	logic [31:0] rd_val;
	logic [5:0]  alarm_now;
	logic [5:0]  alarm_chg;
	logic [5:0]  alarm_clr;
	logic [7:0]  ovf_clr;
	logic        lcv_clr;
	logic        win_end;
	logic [1:0]  zsum;
	logic        few;
	logic [2:0]  ones_next;
	logic        manual_rise;
	logic        auto_tick;
	logic        red_pending;
	logic        any_pending;

	// bus decode
	assign access = APB_I.psel & APB_I.penable;
	assign setup  = APB_I.psel & ~APB_I.penable;
	assign idx    = APB_I.paddr[9:2];
	assign hit    = (APB_I.paddr[11:10] == 2'h0) && (APB_I.paddr[1:0] == 2'h0) &&
		(idx inside {IDX_ALARM_STATUS, IDX_ALARM_IRQ_EN, IDX_ALARM_FLAGS, IDX_CRITERIA,
		IDX_UPDATE_CTRL, IDX_OVF_EN_A, IDX_OVF_EN_B, IDX_OVF_FLAGS_A, IDX_OVF_FLAGS_B});
	assign wr     = access & APB_I.pwrite & hit;

	// write-one clear masks
	assign alarm_clr = (wr && idx == IDX_ALARM_FLAGS) ? APB_I.pwdata[5:0] : 6'h00;
	assign ovf_clr   = (wr && idx == IDX_OVF_FLAGS_A) ? APB_I.pwdata[7:0] : 8'h00;
	assign lcv_clr   = wr && idx == IDX_OVF_FLAGS_B && APB_I.pwdata[BIT_LCV];

	// current alarm states
	assign alarm_now = {FRAMER_I.ts_sixteen_loss_state, FRAMER_I.ts_sixteen_ais_state,
		FRAMER_I.remote_mf_alarm_state, st_reg.all_ones_alarm_state,
		st_reg.remote_alarm_state, st_reg.red_alarm_state};
	assign alarm_chg = alarm_now ^ st_reg.alarm_prev;

	// zero counting over fixed windows
	assign win_end = FRAMER_I.line_bit_valid && st_reg.win_cnt == AIS_WIN_LAST;
	assign zsum    = (st_reg.zero_cnt == 2'h3 || FRAMER_I.line_bit) ? st_reg.zero_cnt :
		st_reg.zero_cnt + 2'h1;
	assign few     = zsum < AIS_FEW_ZEROS;

	// consecutive ones of the a bit
	assign ones_next = (st_reg.a_ones == REMOTE_ONES) ? st_reg.a_ones : st_reg.a_ones + 3'h1;

	// snapshot triggers
	assign manual_rise = wr && idx == IDX_UPDATE_CTRL && APB_I.pwdata[BIT_MANUAL] &&
		!st_reg.manual_counter_snapshot;
	assign auto_tick   = st_reg.auto_counter_snapshot_en &&
		st_reg.sec_cnt == SEC_CNT_W'(SNAP_CYCLES - 1);

	// alignment disagrees with red state
	assign red_pending = FRAMER_I.in_frame_align == st_reg.red_alarm_state;

	// read mux
	always_comb begin
		rd_val = 32'h0000_0000;
		case (idx)
			IDX_ALARM_STATUS: rd_val[5:0] = alarm_now;
			IDX_ALARM_IRQ_EN: rd_val[5:0] = st_reg.alarm_irq_en;
			IDX_ALARM_FLAGS:  rd_val[5:0] = st_reg.alarm_change_flags;
			IDX_CRITERIA: begin
				rd_val[BIT_ALL_ONES_SEL] = st_reg.all_ones_criterion_sel;
				rd_val[BIT_REMOTE_SEL]   = st_reg.remote_alarm_criterion_sel;
			end
			IDX_UPDATE_CTRL: begin
				rd_val[BIT_MANUAL] = st_reg.manual_counter_snapshot;
				rd_val[BIT_AUTO]   = st_reg.auto_counter_snapshot_en;
			end
			IDX_OVF_EN_A:    rd_val[7:0]     = st_reg.ovf_irq_en;
			IDX_OVF_EN_B:    rd_val[BIT_LCV] = st_reg.line_code_viol_ovf_irq_en;
			IDX_OVF_FLAGS_A: rd_val[7:0]     = st_reg.ovf_flags;
			IDX_OVF_FLAGS_B: rd_val[BIT_LCV] = st_reg.line_code_viol_ovf_flag;
			default:         rd_val          = 32'h0000_0000;
		endcase
		if (!hit) begin
			rd_val = 32'h0000_0000;
		end
	end

	// next state
	always_comb begin
		st_next = st_reg;
		if (setup) begin
			st_next.prdata = rd_val;
		end
		if (wr) begin
			case (idx)
				IDX_ALARM_IRQ_EN: st_next.alarm_irq_en = APB_I.pwdata[5:0];
				IDX_CRITERIA: begin
					st_next.all_ones_criterion_sel     = APB_I.pwdata[BIT_ALL_ONES_SEL];
					st_next.remote_alarm_criterion_sel = APB_I.pwdata[BIT_REMOTE_SEL];
				end
				IDX_UPDATE_CTRL: begin
					st_next.manual_counter_snapshot  = APB_I.pwdata[BIT_MANUAL];
					st_next.auto_counter_snapshot_en = APB_I.pwdata[BIT_AUTO];
				end
				IDX_OVF_EN_A: st_next.ovf_irq_en = APB_I.pwdata[7:0];
				IDX_OVF_EN_B: st_next.line_code_viol_ovf_irq_en = APB_I.pwdata[BIT_LCV];
				default: ;
			endcase
		end

		// sticky flags, set wins over clear
		st_next.alarm_prev         = alarm_now;
		st_next.alarm_change_flags = (st_reg.alarm_change_flags & ~alarm_clr) | alarm_chg;
		st_next.ovf_flags = (st_reg.ovf_flags & ~ovf_clr) | FRAMER_I.ovf_event;
		st_next.line_code_viol_ovf_flag = (st_reg.line_code_viol_ovf_flag & ~lcv_clr) |
			FRAMER_I.lcv_ovf_event;

		// red alarm persistence timer
		if (red_pending) begin
			if (st_reg.red_cnt == RED_CNT_W'(RED_CYCLES - 1)) begin
				st_next.red_alarm_state = ~st_reg.red_alarm_state;
				st_next.red_cnt         = '0;
			end else begin
				st_next.red_cnt = st_reg.red_cnt + 1'b1;
			end
		end else begin
			st_next.red_cnt = '0;
		end

		// all-ones detection per window
		if (FRAMER_I.line_bit_valid) begin
			if (win_end) begin
				st_next.win_cnt   = 9'h000;
				st_next.zero_cnt  = 2'h0;
				st_next.prev_few  = few;
				st_next.prev_many = !few;
				if (st_reg.all_ones_criterion_sel) begin
					if (few && st_reg.prev_few) begin
						st_next.all_ones_alarm_state = 1'b1;
					end else if (!few && st_reg.prev_many) begin
						st_next.all_ones_alarm_state = 1'b0;
					end
				end else begin
					if (few && !FRAMER_I.in_frame_align) begin
						st_next.all_ones_alarm_state = 1'b1;
					end else if (!few) begin
						st_next.all_ones_alarm_state = 1'b0;
					end
				end
			end else begin
				st_next.win_cnt  = st_reg.win_cnt + 9'h001;
				st_next.zero_cnt = zsum;
			end
		end

		// remote alarm from a bits
		if (FRAMER_I.a_bit_valid) begin
			if (!FRAMER_I.a_bit) begin
				st_next.a_ones             = 3'h0;
				st_next.remote_alarm_state = 1'b0;
			end else begin
				st_next.a_ones = ones_next;
				if (st_reg.remote_alarm_criterion_sel) begin
					st_next.remote_alarm_state = 1'b1;
				end else if (ones_next == REMOTE_ONES) begin
					st_next.remote_alarm_state = 1'b1;
				end
			end
		end

		// one second snapshot timer
		if (!st_reg.auto_counter_snapshot_en || auto_tick) begin
			st_next.sec_cnt = '0;
		end else begin
			st_next.sec_cnt = st_reg.sec_cnt + 1'b1;
		end
		st_next.snapshot = manual_rise | auto_tick;
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			st_reg                    <= '0;
			st_reg.alarm_irq_en       <= ALARM_RESET;
			st_reg.alarm_change_flags <= ALARM_RESET;
			st_reg.alarm_prev         <= ALARM_RESET;
			st_reg.ovf_irq_en         <= OVF_RESET;
			st_reg.ovf_flags          <= OVF_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign any_pending = |(st_reg.alarm_change_flags & st_reg.alarm_irq_en) |
		|(st_reg.ovf_flags & st_reg.ovf_irq_en) |
		(st_reg.line_code_viol_ovf_flag & st_reg.line_code_viol_ovf_irq_en);
	assign INT_N_O       = ~any_pending;
	assign SNAPSHOT_O    = st_reg.snapshot;
	assign APB_O.prdata  = st_reg.prdata;
	assign APB_O.pready  = 1'b1;
	assign APB_O.pslverr = access & ~hit;

	// checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_win_few;
		win_end && few;
	endsequence

	sequence s_a_one;
		FRAMER_I.a_bit_valid && FRAMER_I.a_bit;
	endsequence

	sequence s_flag_one_write;
		wr && idx == IDX_ALARM_FLAGS && APB_I.pwdata[BIT_RED];
	endsequence

	sequence s_win_many;
		win_end && !few;
	endsequence

	sequence s_a_zero;
		FRAMER_I.a_bit_valid && !FRAMER_I.a_bit;
	endsequence

	sequence s_ovf_one_write;
		wr && idx == IDX_OVF_FLAGS_A && APB_I.pwdata[0];
	endsequence

	sequence s_lcv_one_write;
		lcv_clr;
	endsequence

	a_red_irq_gate: assert property (
		st_reg.alarm_change_flags[BIT_RED] && st_reg.alarm_irq_en[BIT_RED] |-> !INT_N_O)
		else $error("red change flag enabled but interrupt idle");
	a_alarm_edge_flag: assert property (
		$changed(st_reg.red_alarm_state) |=> st_reg.alarm_change_flags[BIT_RED])
		else $error("red state change did not set its flag");
	a_flag_w1c_clear: assert property (
		s_flag_one_write ##0 !alarm_chg[BIT_RED] |=> !st_reg.alarm_change_flags[BIT_RED])
		else $error("write one did not clear red change flag");
	a_ao_single_win: assert property (
		s_win_few ##0 !st_reg.all_ones_criterion_sel && !FRAMER_I.in_frame_align
		|=> st_reg.all_ones_alarm_state)
		else $error("all ones not declared after single window");
	a_ao_two_win: assert property (
		s_win_few ##0 st_reg.all_ones_criterion_sel && st_reg.prev_few
		|=> st_reg.all_ones_alarm_state)
		else $error("all ones not declared after two windows");
	a_ao_two_clear: assert property (
		win_end && !few && st_reg.all_ones_criterion_sel && !st_reg.prev_many
		&& st_reg.all_ones_alarm_state |=> st_reg.all_ones_alarm_state)
		else $error("all ones cleared after a single window");
	a_remote_four: assert property (
		s_a_one ##0 !st_reg.remote_alarm_criterion_sel && st_reg.a_ones == 3'h3
		|=> st_reg.remote_alarm_state)
		else $error("remote alarm not declared after four ones");
	a_remote_zero: assert property (
		FRAMER_I.a_bit_valid && !FRAMER_I.a_bit |=> !st_reg.remote_alarm_state)
		else $error("remote alarm not cleared by zero a bit");
	a_remote_early: assert property (
		!st_reg.remote_alarm_state && !st_reg.remote_alarm_criterion_sel
		&& st_reg.a_ones < 3'h3 |=> !st_reg.remote_alarm_state)
		else $error("remote alarm declared before four ones");
	a_remote_single: assert property (
		s_a_one ##0 st_reg.remote_alarm_criterion_sel |=> st_reg.remote_alarm_state)
		else $error("remote alarm not declared on single one");
	a_manual_snap: assert property (
		manual_rise |=> SNAPSHOT_O ##1 (!SNAPSHOT_O || $past(auto_tick) || $past(manual_rise)))
		else $error("manual snapshot edge missing");
	a_auto_quiet: assert property (
		!st_reg.auto_counter_snapshot_en && !manual_rise |=> !SNAPSHOT_O)
		else $error("snapshot while auto update disabled");
	a_ovf_irq_gate: assert property (
		|(st_reg.ovf_flags & st_reg.ovf_irq_en) |-> !INT_N_O)
		else $error("enabled overflow flag not on interrupt");
	a_lcv_irq_gate: assert property (
		st_reg.line_code_viol_ovf_flag && st_reg.line_code_viol_ovf_irq_en |-> !INT_N_O)
		else $error("enabled line code overflow not on interrupt");
	a_ovf_event_set: assert property (
		FRAMER_I.ovf_event[3] |=> st_reg.ovf_flags[3])
		else $error("overflow event did not set its flag");
	a_red_declare: assert property (
		red_pending && !st_reg.red_alarm_state && st_reg.red_cnt == RED_CNT_W'(RED_CYCLES - 1)
		|=> st_reg.red_alarm_state)
		else $error("red alarm not declared at persistence end");
	a_red_hold: assert property (
		!red_pending |=> $stable(st_reg.red_alarm_state) && st_reg.red_cnt == '0)
		else $error("red alarm moved without persistence");
	a_lcv_set: assert property (
		FRAMER_I.lcv_ovf_event |=> st_reg.line_code_viol_ovf_flag)
		else $error("line code overflow event did not set flag");
	a_irq_release: assert property (
		!INT_N_O |-> (st_reg.alarm_change_flags & st_reg.alarm_irq_en) != 6'h00
		|| (st_reg.ovf_flags & st_reg.ovf_irq_en) != 8'h00
		|| (st_reg.line_code_viol_ovf_flag && st_reg.line_code_viol_ovf_irq_en))
		else $error("interrupt active with no enabled flag");
	a_set_beats_clear: assert property (
		s_flag_one_write ##0 alarm_chg[BIT_RED] |=> st_reg.alarm_change_flags[BIT_RED])
		else $error("event lost against clearing write");
	a_zero_write_keep: assert property (
		wr && idx == IDX_OVF_FLAGS_A && !APB_I.pwdata[0] && st_reg.ovf_flags[0]
		|=> st_reg.ovf_flags[0])
		else $error("zero write cleared an overflow flag");
	a_ts_edge_flag: assert property (
		$changed(FRAMER_I.ts_sixteen_loss_state)
		|=> st_reg.alarm_change_flags[BIT_TS16_LOS])
		else $error("timeslot loss change did not set its flag");
	a_remote_edge_flag: assert property (
		$changed(st_reg.remote_alarm_state) |=> st_reg.alarm_change_flags[BIT_REMOTE])
		else $error("remote state change did not set its flag");
	a_ovf_w1c_clear: assert property (
		s_ovf_one_write ##0 !FRAMER_I.ovf_event[0] |=> !st_reg.ovf_flags[0])
		else $error("write one did not clear an overflow flag");
	a_lcv_w1c_clear: assert property (
		s_lcv_one_write ##0 !FRAMER_I.lcv_ovf_event |=> !st_reg.line_code_viol_ovf_flag)
		else $error("write one did not clear line code overflow flag");
	a_lcv_beats_clear: assert property (
		s_lcv_one_write ##0 FRAMER_I.lcv_ovf_event |=> st_reg.line_code_viol_ovf_flag)
		else $error("line code overflow lost against clearing write");
	a_ovf_beats_clear: assert property (
		s_ovf_one_write ##0 FRAMER_I.ovf_event[0] |=> st_reg.ovf_flags[0])
		else $error("overflow event lost against clearing write");
	a_ao_single_clear: assert property (
		s_win_many ##0 !st_reg.all_ones_criterion_sel |=> !st_reg.all_ones_alarm_state)
		else $error("all ones not cleared after single window");
	a_ao_aligned_hold: assert property (
		s_win_few ##0 !st_reg.all_ones_criterion_sel && FRAMER_I.in_frame_align
		&& !st_reg.all_ones_alarm_state |=> !st_reg.all_ones_alarm_state)
		else $error("all ones declared while in frame alignment");
	a_ao_two_hold: assert property (
		s_win_few ##0 st_reg.all_ones_criterion_sel && !st_reg.prev_few
		&& !st_reg.all_ones_alarm_state |=> !st_reg.all_ones_alarm_state)
		else $error("all ones declared after a single window");
	a_ao_two_release: assert property (
		s_win_many ##0 st_reg.all_ones_criterion_sel && st_reg.prev_many |=> !st_reg.all_ones_alarm_state)
		else $error("all ones not cleared after two windows");
	a_ao_steady: assert property (
		!FRAMER_I.line_bit_valid |=> $stable(st_reg.all_ones_alarm_state))
		else $error("all ones state moved without a line bit");
	a_remote_steady: assert property (
		!FRAMER_I.a_bit_valid |=> $stable(st_reg.remote_alarm_state))
		else $error("remote state moved without an a bit");
	a_remote_zero_sel: assert property (
		s_a_zero ##0 st_reg.remote_alarm_criterion_sel |=> !st_reg.remote_alarm_state)
		else $error("remote alarm not cleared by zero in single mode");
	a_red_clear: assert property (
		red_pending && st_reg.red_alarm_state && st_reg.red_cnt == RED_CNT_W'(RED_CYCLES - 1)
		|=> !st_reg.red_alarm_state)
		else $error("red alarm not cleared at persistence end");
	a_snap_single: assert property (
		SNAPSHOT_O && !manual_rise && !auto_tick |=> !SNAPSHOT_O)
		else $error("snapshot pulse longer than one cycle");
	a_manual_held: assert property (
		wr && idx == IDX_UPDATE_CTRL && APB_I.pwdata[BIT_MANUAL]
		&& st_reg.manual_counter_snapshot && !auto_tick |=> !SNAPSHOT_O)
		else $error("snapshot without a manual bit rise");
	a_auto_from_zero: assert property (
		$rose(st_reg.auto_counter_snapshot_en) |-> st_reg.sec_cnt == '0)
		else $error("second timer not restarted at enable");
	a_alarm_flags_keep: assert property (
		alarm_chg == 6'h00 && alarm_clr == 6'h00 |=> $stable(st_reg.alarm_change_flags))
		else $error("alarm change flags moved without event or clear");
	a_int_masked: assert property (
		st_reg.alarm_irq_en == 6'h00 && st_reg.ovf_irq_en == 8'h00
		&& !st_reg.line_code_viol_ovf_irq_en |-> INT_N_O)
		else $error("interrupt active with every enable off");

endmodule : e1_alarm_event_ctrl

//--- dv/framer_model.sv
// receive framer stand-in driving alarm levels, line bits, a bits and overflows
`timescale 1ns/1ps
module framer_model (
	input  wire logic                     clk_i,
	output alarm_event_pkg::framer_in_type framer_o
);
	import alarm_event_pkg::*;

	initial begin
		framer_o = '0;
		framer_o.in_frame_align = 1'b1;
	end

	// alignment and timeslot sixteen detector levels
	task automatic lv(input logic al, input logic [2:0] ts);
		framer_o.in_frame_align <= al;
		framer_o.ts_sixteen_loss_state <= ts[2];
		framer_o.ts_sixteen_ais_state <= ts[1];
		framer_o.remote_mf_alarm_state <= ts[0];
		@(posedge clk_i);
	endtask : lv

	// one pulse per counter overflow
	task automatic ovf(input logic [7:0] m, input logic l);
		framer_o.ovf_event <= m;
		framer_o.lcv_ovf_event <= l;
		@(posedge clk_i);
		framer_o.ovf_event <= 8'h00;
		framer_o.lcv_ovf_event <= 1'b0;
	endtask : ovf

	// one a bit, value inverted once invalid
	task automatic abit(input logic v);
		framer_o.a_bit_valid <= 1'b1;
		framer_o.a_bit <= v;
		@(posedge clk_i);
		framer_o.a_bit_valid <= 1'b0;
		framer_o.a_bit <= ~v;
		@(posedge clk_i);
	endtask : abit

	// n line bits, the first z of them zero
	task automatic bits(input int n, input int z);
		for (int i = 0; i < n; i++) begin
			framer_o.line_bit_valid <= 1'b1;
			framer_o.line_bit <= (i >= z);
			@(posedge clk_i);
		end
		framer_o.line_bit_valid <= 1'b0;
		framer_o.line_bit <= ~framer_o.line_bit;
		@(posedge clk_i);
	endtask : bits
endmodule : framer_model

//--- dv/testbench.sv
// self-checking bench for the per-line alarm event block
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin failures++; \
	$display("FAIL %0t %s got %0h exp %0h", $time, m, a, b); end end
module testbench;
	import alarm_event_pkg::*;
	localparam int RED_SIM  = 20;
	localparam int SNAP_SIM = 50;
	logic          CLK_I;
	logic          SYS_RST_I;
	apb_req_type   apb_req;
	apb_rsp_type   apb_rsp;
	framer_in_type framer;
	logic          INT_N_O;
	logic          SNAPSHOT_O;
	int            failures;
	int            checks;
	int            seed;
	int            n;
	logic [31:0]   rdat;
	logic          rerr;
	logic [7:0]    m;
	logic [7:0]    e;
	logic [7:0]    c;
	logic          lcv;
	logic [7:0]    regs [9] = '{IDX_ALARM_STATUS, IDX_ALARM_IRQ_EN, IDX_ALARM_FLAGS,
		IDX_CRITERIA, IDX_UPDATE_CTRL, IDX_OVF_EN_A, IDX_OVF_EN_B, IDX_OVF_FLAGS_A,
		IDX_OVF_FLAGS_B};

	e1_alarm_event_ctrl #(.RED_CYCLES(RED_SIM), .SNAP_CYCLES(SNAP_SIM)) dut_u (
		.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .APB_I(apb_req), .APB_O(apb_rsp),
		.FRAMER_I(framer), .INT_N_O(INT_N_O), .SNAPSHOT_O(SNAPSHOT_O));
	framer_model model_u (.clk_i(CLK_I), .framer_o(framer));

	initial begin
		CLK_I = 1'b0;
		forever #4 CLK_I = ~CLK_I;
	end

	task automatic end_sim;
		if (failures == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	// one apb transfer, read data and error kept
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int k;
		@(posedge CLK_I);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'h0, idx, 2'h0}, pwdata: d};
		@(posedge CLK_I);
		apb_req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge CLK_I);
			k++;
		end while (apb_rsp.pready !== 1'b1 && k < 16);
		if (apb_rsp.pready === 1'b1) begin
			rdat = apb_rsp.prdata;
			rerr = apb_rsp.pslverr;
			apb_req.psel <= 1'b0;
			apb_req.penable <= 1'b0;
		end else begin
			failures++;
			end_sim();
		end
	endtask : apb

	// status bit after a read
	task automatic sbit(input int b, input logic v);
		apb(1'b0, IDX_ALARM_STATUS, 32'h0);
		`CHK(rdat[b], v, "status bit")
	endtask : sbit

	task automatic pulses(input int len, output int cnt);
		cnt = 0;
		repeat (len) begin
			@(posedge CLK_I);
			if (SNAPSHOT_O === 1'b1) cnt++;
		end
	endtask : pulses

	initial begin
		repeat (100000) @(posedge CLK_I);
		failures++;
		end_sim();
	end

	initial begin
		seed = 12658;
		failures = 0;
		checks = 0;
		apb_req = '0;
		SYS_RST_I = 1'b1;
		repeat (20) @(posedge CLK_I);
		SYS_RST_I <= 1'b0;
		`CHK(INT_N_O, 1'b1, "int idle")
		foreach (regs[i]) begin
			apb(1'b0, regs[i], 32'h0);
			`CHK(rdat, 32'h0, "reset value")
		end
		apb(1'b0, 8'hBD, 32'h0);
		`CHK({rerr, rdat}, 33'h100000000, "unmapped")
		apb(1'b1, IDX_OVF_EN_B, 32'hFFFFFFFF);
		apb(1'b0, IDX_OVF_EN_B, 32'h0);
		`CHK(rdat, 32'h1, "enable b width")
		repeat (8) begin
			m = 8'($random(seed));
			e = 8'($random(seed));
			c = 8'($random(seed));
			lcv = 1'($random(seed));
			model_u.ovf(m, lcv);
			apb(1'b1, IDX_OVF_EN_A, {24'h0, e});
			@(posedge CLK_I);
			`CHK(INT_N_O, ~(|(m & e) | lcv), "ovf gate")
			apb(1'b1, IDX_OVF_FLAGS_A, 32'h0);
			apb(1'b0, IDX_OVF_FLAGS_A, 32'h0);
			`CHK(rdat, {24'h0, m}, "zero write")
			apb(1'b1, IDX_OVF_FLAGS_A, {24'h0, c});
			apb(1'b0, IDX_OVF_FLAGS_A, 32'h0);
			`CHK(rdat, {24'h0, m & ~c}, "partial clear")
			apb(1'b0, IDX_OVF_FLAGS_B, 32'h0);
			`CHK(rdat, {31'h0, lcv}, "lcv random")
			apb(1'b1, IDX_OVF_FLAGS_A, 32'hFF);
			apb(1'b1, IDX_OVF_FLAGS_B, 32'h1);
		end
		model_u.ovf(8'h00, 1'b1);
		apb(1'b0, IDX_OVF_FLAGS_B, 32'h0);
		`CHK(rdat, 32'h1, "lcv flag")
		`CHK(INT_N_O, 1'b0, "lcv int")
		apb(1'b1, IDX_OVF_EN_B, 32'h0);
		@(posedge CLK_I);
		`CHK(INT_N_O, 1'b1, "lcv masked")
		apb(1'b1, IDX_OVF_FLAGS_B, 32'h1);
		apb(1'b0, IDX_OVF_FLAGS_B, 32'h0);
		`CHK(rdat, 32'h0, "lcv clear")
		model_u.ovf(8'h81, 1'b0);
		fork
			apb(1'b1, IDX_OVF_FLAGS_A, 32'hFF);
			begin
				@(posedge CLK_I);
				@(posedge CLK_I);
				model_u.ovf(8'h01, 1'b0);
			end
		join
		apb(1'b0, IDX_OVF_FLAGS_A, 32'h0);
		`CHK(rdat, 32'h1, "set beats clear")
		apb(1'b1, IDX_OVF_FLAGS_A, 32'hFF);
		repeat (3) model_u.abit(1'b1);
		model_u.abit(1'b0);
		repeat (3) model_u.abit(1'b1);
		sbit(BIT_REMOTE, 1'b0);
		model_u.abit(1'b1);
		sbit(BIT_REMOTE, 1'b1);
		apb(1'b1, IDX_ALARM_FLAGS, 32'h3F);
		model_u.abit(1'b0);
		sbit(BIT_REMOTE, 1'b0);
		apb(1'b0, IDX_ALARM_FLAGS, 32'h0);
		`CHK(rdat, 32'h2, "remote change")
		apb(1'b1, IDX_CRITERIA, 32'h1);
		model_u.abit(1'b1);
		sbit(BIT_REMOTE, 1'b1);
		model_u.abit(1'b0);
		sbit(BIT_REMOTE, 1'b0);
		apb(1'b1, IDX_ALARM_FLAGS, 32'h3F);
		model_u.lv(1'b1, 3'b111);
		apb(1'b0, IDX_ALARM_FLAGS, 32'h0);
		`CHK(rdat, 32'h38, "ts16 change")
		apb(1'b1, IDX_ALARM_IRQ_EN, 32'h08);
		@(posedge CLK_I);
		`CHK(INT_N_O, 1'b0, "alarm int")
		apb(1'b1, IDX_ALARM_FLAGS, 32'h08);
		@(posedge CLK_I);
		`CHK(INT_N_O, 1'b1, "alarm int off")
		e = 8'h07;
		repeat (4) begin
			c = 8'($random(seed));
			apb(1'b1, IDX_ALARM_FLAGS, 32'h3F);
			model_u.lv(1'b1, c[2:0]);
			apb(1'b0, IDX_ALARM_FLAGS, 32'h0);
			`CHK(rdat, {26'h0, e[2:0] ^ c[2:0], 3'h0}, "ts16 random")
			e = c;
		end
		apb(1'b1, IDX_ALARM_IRQ_EN, 32'h01);
		apb(1'b1, IDX_ALARM_FLAGS, 32'h3F);
		model_u.lv(1'b0, 3'b000);
		apb(1'b1, IDX_ALARM_FLAGS, 32'h38);
		repeat (RED_SIM - 6) @(posedge CLK_I);
		sbit(BIT_RED, 1'b0);
		repeat (10) @(posedge CLK_I);
		sbit(BIT_RED, 1'b1);
		`CHK(INT_N_O, 1'b0, "red int")
		apb(1'b1, IDX_ALARM_IRQ_EN, 32'h0);
		@(posedge CLK_I);
		`CHK(INT_N_O, 1'b1, "red masked")
		apb(1'b1, IDX_ALARM_FLAGS, 32'h3F);
		model_u.bits(512, 2);
		sbit(BIT_ALL_ONES, 1'b1);
		apb(1'b0, IDX_ALARM_FLAGS, 32'h0);
		`CHK(rdat, 32'h4, "all ones change")
		model_u.bits(512, 3);
		sbit(BIT_ALL_ONES, 1'b0);
		apb(1'b1, IDX_CRITERIA, 32'h2);
		model_u.bits(512, 0);
		sbit(BIT_ALL_ONES, 1'b0);
		model_u.bits(512, 1);
		sbit(BIT_ALL_ONES, 1'b1);
		model_u.bits(512, 3);
		sbit(BIT_ALL_ONES, 1'b1);
		model_u.bits(512, 4);
		sbit(BIT_ALL_ONES, 1'b0);
		apb(1'b1, IDX_CRITERIA, 32'h0);
		model_u.lv(1'b1, 3'b000);
		model_u.bits(512, 0);
		sbit(BIT_ALL_ONES, 1'b0);
		sbit(BIT_RED, 1'b0);
		apb(1'b1, IDX_UPDATE_CTRL, 32'h2);
		pulses(5, n);
		`CHK(n, 1, "manual snapshot")
		apb(1'b1, IDX_UPDATE_CTRL, 32'h1);
		pulses(160, n);
		`CHK(n, 3, "auto snapshot")
		apb(1'b1, IDX_UPDATE_CTRL, 32'h0);
		pulses(120, n);
		`CHK(n, 0, "auto stopped")
		end_sim();
	end
endmodule : testbench
